// File: cpusc_regs.svh
`ifndef CPUSC_REGS_SVH
`define CPUSC_REGS_SVH

// Special function register byte addresses inside the core window
`define CPUSC_ADDR_WIDTH      10
`define CPUSC_ADDR_FLAGS      10'h200
`define CPUSC_ADDR_MODE       10'h201
`define CPUSC_ADDR_CONFIG     10'h202

// status_flag_byte bit positions
`define CPUSC_FLAG_ZERO       0
`define CPUSC_FLAG_SIGN       1
`define CPUSC_FLAG_OVF        2
`define CPUSC_FLAG_HALF       6
`define CPUSC_FLAG_CARRY      7
`define CPUSC_FLAG_MASK       8'hC7

// operating_mode_byte bit positions
`define CPUSC_MODE_PRIO_LO    0
`define CPUSC_MODE_BANK_LO    4
`define CPUSC_MODE_BANK_HI    5
`define CPUSC_MODE_TRACE      6
`define CPUSC_MODE_SYS        7
`define CPUSC_MODE_BANK_MASK  8'h30
`define CPUSC_MODE_PRIV_MASK  8'hCF

// system_config_reg bit positions
`define CPUSC_CFG_DIV_LO      0
`define CPUSC_CFG_DIV_HI      1
`define CPUSC_CFG_COMPAT      2
`define CPUSC_CFG_PAGE0       3
`define CPUSC_CFG_MASK        8'h0F

// Config reset value and highest priority mask; status word comes from the reset vector instead
`define CPUSC_CONFIG_RESET    8'h00
`define CPUSC_PRIO_MAX        4'hF

// Peripheral clock division counts
`define CPUSC_DIV_4           8'h03
`define CPUSC_DIV_16          8'h0F
`define CPUSC_DIV_64          8'h3F

`endif

// File: cpusc_pkg.sv
package cpusc_pkg;

   // Flag update class of the instruction being retired
   typedef enum logic [3:0] {
      CPUSC_OP_NONE,
      CPUSC_OP_ADD,
      CPUSC_OP_CMPJ,
      CPUSC_OP_DECADJ,
      CPUSC_OP_NEG,
      CPUSC_OP_SHIFT,
      CPUSC_OP_MUL,
      CPUSC_OP_DIV,
      CPUSC_OP_MOVE,
      CPUSC_OP_KEEP
   } cpusc_op_type;

   // Peripheral clock divider selection
   typedef enum logic [1:0] {
      CPUSC_PDIV_4,
      CPUSC_PDIV_16,
      CPUSC_PDIV_64,
      CPUSC_PDIV_RSVD
   } cpusc_pdiv_type;

endpackage

// File: cpusc_alu_if.sv
`timescale 1ns/1ps
interface cpusc_alu_if;
   cpusc_pkg::cpusc_op_type op;
   logic                    valid;
   logic                    carry_in;
   logic                    half_in;
   logic                    ovf_in;
   logic                    msb_in;
   logic                    zero_in;
   logic                    shift_out;
   logic                    carry;
   logic                    half;
   logic                    ovf;

   modport calc (input op, valid, carry_in, half_in, ovf_in, msb_in, zero_in, shift_out,
                 output carry, half, ovf);
   modport use_flags (output op, valid, carry_in, half_in, ovf_in, msb_in, zero_in, shift_out,
                      input carry, half, ovf);
endinterface

// File: cpusc_flag_calc.sv
`timescale 1ns/1ps
module cpusc_flag_calc (
   // Arithmetic results in, flag values out
   cpusc_alu_if.calc a,
   input  wire logic carry_reg,
   input  wire logic half_reg,
   input  wire logic ovf_reg
);
   always_comb begin
      a.carry = carry_reg;
      a.half  = half_reg;
      a.ovf   = ovf_reg;
      case (a.valid ? a.op : cpusc_pkg::CPUSC_OP_NONE)
         cpusc_pkg::CPUSC_OP_ADD: begin
            a.carry = a.carry_in;
            a.half  = a.half_in;
            a.ovf   = a.ovf_in;
         end
         cpusc_pkg::CPUSC_OP_CMPJ,
         cpusc_pkg::CPUSC_OP_DECADJ: a.carry = a.carry_in;
         cpusc_pkg::CPUSC_OP_NEG:    a.ovf   = a.ovf_in;
         cpusc_pkg::CPUSC_OP_SHIFT:  a.carry = a.shift_out;
         cpusc_pkg::CPUSC_OP_MUL: begin
            a.carry = 1'b0;
            a.ovf   = a.ovf_in;
         end
         cpusc_pkg::CPUSC_OP_DIV: begin
            a.carry = 1'b0;
            a.ovf   = a.ovf_in;
         end
         default: ;
      endcase
   end
endmodule // cpusc_flag_calc

// File: cpusc_core_status.sv
// Summary of operation
// - Add, compare, subtract and decimal adjust load carry from top result bit.
// - Shifts and carry rotates pass their bit through the carry flag.
// - Every multiply and divide clears the carry flag.
// - Add and subtract load the half flag from the nibble carry; compare keeps it.
// - Add, negate and subtract set overflow on signed overflow; compare keeps it.
// - Divide sets overflow on quotient too wide or divisor zero.
// - Multiply sets overflow when product exceeds source operand size.
// - Sign flag copies result msb; stack, extend, address and exchange keep it.
// - Zero flag follows result zero; same instructions keep it unchanged.
// - Mode byte writable only in system mode, bank bits always.
// - System bit grants privilege; clear means user mode.
// - Trace bit enables single-step debug facilities.
// - Two bank bits select one of four low register banks.
// - Priority mask gates event interrupts; 15 still passes exceptions and NMI.
// - Explicit status byte write beats instruction flag updates, but a vector load beats it; other byte kept.
// - Reset loads status word from program address 0 vector.
// - Page zero bit chooses 16-bit addressing, else 24-bit.
// - Calls push 24 address bits, or one 16-bit word in page zero.
// - Compat mode maps low 32 data bytes onto four register banks.
// - Compat indirect through register 0 or 1 uses zero-extended byte.
// - Prescale field divides oscillator by 4, 16 or 64; 11 reserved.
// - Status byte is readable and writable in either mode.
`timescale 1ns/1ps
`include "cpusc_regs.svh"
module cpusc_core_status #(
   parameter int DATA_W = 16
) (
   // Clock and reset
   input  wire logic                            clk_sys,
   input  wire logic                            nrst,
   // Reset vector word fetched from address 0
   input  wire logic                            vec_load,
   input  wire logic [15:0]                     vec_word,
   // Special function register port
   input  wire logic [`CPUSC_ADDR_WIDTH-1:0]    sfr_addr,
   input  wire logic                            sfr_wr,
   input  wire logic [7:0]                      sfr_wdata,
   output logic      [7:0]                      sfr_rdata,
   // Retiring instruction results
   input  wire logic                            res_valid,
   input  wire cpusc_pkg::cpusc_op_type         res_op,
   input  wire logic [DATA_W-1:0]               res_value,
   input  wire logic                            res_wide,
   input  wire logic                            res_carry,
   input  wire logic                            res_half,
   input  wire logic                            res_ovf,
   input  wire logic                            res_shift_out,
   // Interrupt priority check
   input  wire logic [3:0]                      irq_prio,
   input  wire logic                            irq_is_exc,
   output logic                                 irq_accept,
   // Mode outputs
   output logic                                 priv_mode,
   output logic                                 trace_en,
   output logic      [1:0]                      bank_sel,
   output logic                                 addr_16bit,
   output logic                                 push_word_only,
   output logic                                 compat_map,
   // Legacy compatibility address mapping
   input  wire logic [15:0]                     dmem_addr,
   input  wire logic                            ind_via_r1,
   input  wire logic [15:0]                     reg0_word,
   output logic                                 dmem_is_reg,
   output logic      [1:0]                      dmem_bank,
   output logic      [2:0]                      dmem_byte,
   output logic      [15:0]                     ind_pointer,
   // Peripheral timing enable
   output logic                                 periph_tick
);
   logic [7:0] flags_reg, flags_next;
   logic [7:0] mode_reg, mode_next;
   logic [7:0] cfg_reg, cfg_next;
   logic [7:0] div_reg, div_next;
   logic       tick_reg, tick_next;
   logic [DATA_W-1:0] res_masked;
   logic       res_msb;
   logic       psw_wr;

   cpusc_alu_if alu ();

   assign alu.op        = res_op;
   assign alu.valid     = res_valid;
   assign alu.carry_in  = res_carry;
   assign alu.half_in   = res_half;
   assign alu.ovf_in    = res_ovf;
   assign alu.msb_in    = res_msb;
   assign alu.zero_in   = (res_masked == '0);
   assign alu.shift_out = res_shift_out;

   assign psw_wr = sfr_wr && (addr_hit(sfr_addr, `CPUSC_ADDR_FLAGS)
                              || addr_hit(sfr_addr, `CPUSC_ADDR_MODE));

   cpusc_flag_calc u_calc (
      .a         (alu),
      .carry_reg (flags_reg[`CPUSC_FLAG_CARRY]),
      .half_reg  (flags_reg[`CPUSC_FLAG_HALF]),
      .ovf_reg   (flags_reg[`CPUSC_FLAG_OVF])
   );

   function automatic logic addr_hit(input logic [`CPUSC_ADDR_WIDTH-1:0] a,
                                     input logic [`CPUSC_ADDR_WIDTH-1:0] b);
      addr_hit = (a == b);
   endfunction

   // Byte results live in the low half
   always_comb begin
      res_masked = res_value;
      res_msb    = res_value[DATA_W-1];
      if (!res_wide) begin
         res_masked = {{(DATA_W-8){1'b0}}, res_value[7:0]};
         res_msb    = res_value[7];
      end
   end

   always_comb begin
      flags_next = flags_reg;
      mode_next  = mode_reg;
      cfg_next   = cfg_reg;
      if (res_valid && res_op != cpusc_pkg::CPUSC_OP_NONE
          && res_op != cpusc_pkg::CPUSC_OP_KEEP && !psw_wr) begin
         flags_next[`CPUSC_FLAG_CARRY] = alu.carry;
         flags_next[`CPUSC_FLAG_HALF]  = alu.half;
         flags_next[`CPUSC_FLAG_OVF]   = alu.ovf;
         flags_next[`CPUSC_FLAG_SIGN]  = alu.msb_in;
         flags_next[`CPUSC_FLAG_ZERO]  = alu.zero_in;
      end
      if (sfr_wr && addr_hit(sfr_addr, `CPUSC_ADDR_FLAGS)) begin
         flags_next = sfr_wdata & `CPUSC_FLAG_MASK;
      end
      if (sfr_wr && addr_hit(sfr_addr, `CPUSC_ADDR_MODE)) begin
         if (mode_reg[`CPUSC_MODE_SYS]) begin
            mode_next = sfr_wdata;
         end else begin
            mode_next = (mode_reg & `CPUSC_MODE_PRIV_MASK)
                        | (sfr_wdata & `CPUSC_MODE_BANK_MASK);
         end
      end
      if (sfr_wr && addr_hit(sfr_addr, `CPUSC_ADDR_CONFIG) && mode_reg[`CPUSC_MODE_SYS]) begin
         cfg_next = sfr_wdata & `CPUSC_CFG_MASK;
      end
      if (vec_load) begin
         flags_next = vec_word[7:0] & `CPUSC_FLAG_MASK;
         mode_next  = vec_word[15:8];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         flags_reg <= 8'h00;
         mode_reg  <= 8'h00;
         cfg_reg   <= `CPUSC_CONFIG_RESET;
      end else begin
         flags_reg <= flags_next;
         mode_reg  <= mode_next;
         cfg_reg   <= cfg_next;
      end
   end

   // Register readback
   always_comb begin
      sfr_rdata = 8'h00;
      if (addr_hit(sfr_addr, `CPUSC_ADDR_FLAGS)) begin
         sfr_rdata = flags_reg;
      end else if (addr_hit(sfr_addr, `CPUSC_ADDR_MODE)) begin
         sfr_rdata = mode_reg;
      end else if (addr_hit(sfr_addr, `CPUSC_ADDR_CONFIG)) begin
         sfr_rdata = cfg_reg;
      end
   end

   assign priv_mode = mode_reg[`CPUSC_MODE_SYS];
   assign trace_en  = mode_reg[`CPUSC_MODE_TRACE];
   assign bank_sel  = {mode_reg[`CPUSC_MODE_BANK_HI], mode_reg[`CPUSC_MODE_BANK_LO]};

   always_comb begin
      irq_accept = irq_is_exc
                   || (irq_prio > mode_reg[`CPUSC_MODE_PRIO_LO +: 4]
                       && mode_reg[`CPUSC_MODE_PRIO_LO +: 4] != `CPUSC_PRIO_MAX);
   end

   assign addr_16bit     = cfg_reg[`CPUSC_CFG_PAGE0];
   assign push_word_only = cfg_reg[`CPUSC_CFG_PAGE0];
   assign compat_map     = cfg_reg[`CPUSC_CFG_COMPAT];

   always_comb begin
      dmem_is_reg = compat_map && (dmem_addr[15:5] == 11'h000);
      dmem_bank   = dmem_addr[4:3];
      dmem_byte   = dmem_addr[2:0];
   end

   always_comb begin
      ind_pointer = reg0_word;
      if (compat_map) begin
         ind_pointer = ind_via_r1 ? {8'h00, reg0_word[15:8]} : {8'h00, reg0_word[7:0]};
      end
   end

   always_comb begin
      div_next  = div_reg + 8'h01;
      tick_next = 1'b0;
      case (cpusc_pkg::cpusc_pdiv_type'(cfg_reg[`CPUSC_CFG_DIV_HI:`CPUSC_CFG_DIV_LO]))
         cpusc_pkg::CPUSC_PDIV_4:  tick_next = (div_reg >= `CPUSC_DIV_4);
         cpusc_pkg::CPUSC_PDIV_16: tick_next = (div_reg >= `CPUSC_DIV_16);
         cpusc_pkg::CPUSC_PDIV_64: tick_next = (div_reg >= `CPUSC_DIV_64);
         default:                  tick_next = 1'b0;
      endcase
      if (tick_next) begin
         div_next = 8'h00;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         div_reg  <= 8'h00;
         tick_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
      end
   end

   assign periph_tick = tick_reg;
endmodule // cpusc_core_status

// File: cpusc_monitor.sv
`timescale 1ns/1ps
`include "cpusc_regs.svh"
module cpusc_monitor (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        nrst,
   // Register access
   input wire logic        vec_load,
   input wire logic [15:0] vec_word,
   input wire logic [9:0]  sfr_addr,
   input wire logic        sfr_wr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        res_valid,
   // Interrupt check, mode outputs and address mapping
   input wire logic [3:0]  irq_prio,
   input wire logic        irq_is_exc,
   input wire logic        irq_accept,
   input wire logic        priv_mode,
   input wire logic        trace_en,
   input wire logic [1:0]  bank_sel,
   input wire logic        compat_map,
   input wire logic [15:0] dmem_addr,
   input wire logic        dmem_is_reg,
   input wire logic [1:0]  dmem_bank,
   input wire logic [2:0]  dmem_byte,
   input wire logic        periph_tick
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic mode_wr;
   logic cfg_wr;
   // Vector load outranks a flag or mode register write in the same cycle; a config write still lands
   assign mode_wr = sfr_wr && !vec_load && sfr_addr == `CPUSC_ADDR_MODE;
   assign cfg_wr  = sfr_wr && !vec_load && sfr_addr == `CPUSC_ADDR_CONFIG;
   property p_mode_sys;
      mode_wr && priv_mode |=> {priv_mode, trace_en, bank_sel} == $past(sfr_wdata[7:4]);
   endproperty
   a_mode_sys: assert property (p_mode_sys) else $error("mode write lost");
   property p_mode_user;
      mode_wr && !priv_mode |=> !priv_mode && $stable(trace_en)
         && bank_sel == $past(sfr_wdata[5:4]);
   endproperty
   a_mode_user: assert property (p_mode_user) else $error("user mode write");
   property p_cfg_user;
      cfg_wr && !priv_mode |=> $stable(compat_map);
   endproperty
   a_cfg_user: assert property (p_cfg_user) else $error("user config write");
   property p_vec;
      vec_load |=> {priv_mode, trace_en, bank_sel} == $past(vec_word[15:12]);
   endproperty
   a_vec: assert property (p_vec) else $error("vector load lost");
   property p_irq;
      sfr_addr == `CPUSC_ADDR_MODE |-> irq_accept == (irq_is_exc
         || (irq_prio > sfr_rdata[3:0] && sfr_rdata[3:0] != 4'hF));
   endproperty
   a_irq: assert property (p_irq) else $error("priority gate wrong");
   property p_rsvd;
      sfr_addr == `CPUSC_ADDR_FLAGS |-> sfr_rdata[5:3] == 3'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved flag bit set");
   property p_flag_wins;
      sfr_wr && !vec_load && res_valid && sfr_addr == `CPUSC_ADDR_FLAGS
         |=> sfr_addr != `CPUSC_ADDR_FLAGS
             || sfr_rdata == ($past(sfr_wdata) & `CPUSC_FLAG_MASK);
   endproperty
   a_flag_wins: assert property (p_flag_wins) else $error("flag write lost");
   property p_tick;
      periph_tick |=> !periph_tick [*3];
   endproperty
   a_tick: assert property (p_tick) else $error("tick too close");
   property p_compat;
      compat_map && dmem_addr < 16'h0020 |-> dmem_is_reg
         && 16'(dmem_bank) * 16'h0008 + 16'(dmem_byte) == dmem_addr;
   endproperty
   a_compat: assert property (p_compat) else $error("bank map wrong");
   property p_native;
      !compat_map || dmem_addr >= 16'h0020 |-> !dmem_is_reg;
   endproperty
   a_native: assert property (p_native) else $error("register map outside window");
endmodule // cpusc_monitor

bind cpusc_core_status cpusc_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst),
   .vec_load(vec_load), .vec_word(vec_word), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .res_valid(res_valid),
   .irq_prio(irq_prio), .irq_is_exc(irq_is_exc), .irq_accept(irq_accept),
   .priv_mode(priv_mode), .trace_en(trace_en), .bank_sel(bank_sel),
   .compat_map(compat_map), .dmem_addr(dmem_addr), .dmem_is_reg(dmem_is_reg),
   .dmem_bank(dmem_bank), .dmem_byte(dmem_byte), .periph_tick(periph_tick));

// File: tb.sv
`timescale 1ns/1ps
`include "cpusc_regs.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb;
   // Bench state
   int                      error_cnt = 0;
   int                      check_count = 0;
   logic [7:0]              n;
   // Stimulus
   logic                    clk_sys, nrst, vec_load, sfr_wr, res_valid, res_wide;
   logic                    res_carry, res_half, res_ovf, res_shift_out, irq_is_exc;
   logic                    ind_via_r1;
   logic [15:0]             vec_word, res_value, dmem_addr, reg0_word;
   logic [9:0]              sfr_addr;
   logic [7:0]              sfr_wdata;
   logic [3:0]              irq_prio;
   cpusc_pkg::cpusc_op_type res_op;
   // Observed
   logic [7:0]              sfr_rdata;
   logic [1:0]              bank_sel, dmem_bank;
   logic [2:0]              dmem_byte;
   logic [15:0]             ind_pointer;
   logic                    irq_accept, priv_mode, trace_en, addr_16bit, push_word_only;
   logic                    compat_map, dmem_is_reg, periph_tick;

   cpusc_core_status dut (.clk_sys(clk_sys), .nrst(nrst), .vec_load(vec_load),
      .vec_word(vec_word), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .res_valid(res_valid), .res_op(res_op), .res_value(res_value),
      .res_wide(res_wide), .res_carry(res_carry), .res_half(res_half), .res_ovf(res_ovf),
      .res_shift_out(res_shift_out), .irq_prio(irq_prio), .irq_is_exc(irq_is_exc),
      .irq_accept(irq_accept), .priv_mode(priv_mode), .trace_en(trace_en),
      .bank_sel(bank_sel), .addr_16bit(addr_16bit), .push_word_only(push_word_only),
      .compat_map(compat_map), .dmem_addr(dmem_addr), .ind_via_r1(ind_via_r1),
      .reg0_word(reg0_word), .dmem_is_reg(dmem_is_reg), .dmem_bank(dmem_bank),
      .dmem_byte(dmem_byte), .ind_pointer(ind_pointer), .periph_tick(periph_tick));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge clk_sys);
      sfr_wr    <= 1'b0;
   endtask

   // Readback is combinational, so settle past the edge first
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      sfr_addr <= a;
      #1;
      `CHK(sfr_rdata, e)
   endtask

   task automatic ex(input cpusc_pkg::cpusc_op_type op, input logic [15:0] v,
                     input logic w, input logic [3:0] chvs);
      @(posedge clk_sys);
      res_valid <= 1'b1;
      res_op    <= op;
      res_value <= v;
      res_wide  <= w;
      {res_carry, res_half, res_ovf, res_shift_out} <= chvs;
      @(posedge clk_sys);
      res_valid <= 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      finish_test();
   end

   initial begin
      {nrst, vec_load, sfr_wr, res_valid, res_wide, irq_is_exc, ind_via_r1} = '0;
      {res_carry, res_half, res_ovf, res_shift_out} = '0;
      {vec_word, res_value, dmem_addr, sfr_addr, sfr_wdata, irq_prio} = '0;
      reg0_word = 16'hA55A;
      res_op = cpusc_pkg::CPUSC_OP_NONE;
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(`CPUSC_ADDR_CONFIG, 8'h00);
      `CHK(priv_mode, 1'b0)
      wr(`CPUSC_ADDR_CONFIG, 8'h0F);
      rd(`CPUSC_ADDR_CONFIG, 8'h00);
      wr(`CPUSC_ADDR_MODE, 8'hFF);
      rd(`CPUSC_ADDR_MODE, 8'h30);
      wr(`CPUSC_ADDR_FLAGS, 8'hFF);
      rd(`CPUSC_ADDR_FLAGS, 8'hC7);
      rd(10'h203, 8'h00);
      @(posedge clk_sys);
      vec_word <= 16'h8FFF;
      vec_load <= 1'b1;
      @(posedge clk_sys);
      vec_load <= 1'b0;
      rd(`CPUSC_ADDR_MODE, 8'h8F);
      wr(`CPUSC_ADDR_MODE, 8'hE5);
      rd(`CPUSC_ADDR_MODE, 8'hE5);
      `CHK({priv_mode, trace_en, bank_sel}, 4'hE)
      for (int p = 0; p < 16; p++) begin
         @(posedge clk_sys);
         irq_prio <= p[3:0];
         #1;
         `CHK(irq_accept, p > 5)
      end
      wr(`CPUSC_ADDR_MODE, 8'hCF);
      @(posedge clk_sys);
      #1;
      `CHK(irq_accept, 1'b0)
      @(posedge clk_sys);
      irq_is_exc <= 1'b1;
      #1;
      `CHK(irq_accept, 1'b1)
      // Flag updates from retiring instructions
      wr(`CPUSC_ADDR_FLAGS, 8'h00);
      ex(cpusc_pkg::CPUSC_OP_ADD, 16'h0080, 1'b0, 4'hE);
      rd(`CPUSC_ADDR_FLAGS, 8'hC6);
      ex(cpusc_pkg::CPUSC_OP_ADD, 16'h0000, 1'b1, 4'h0);
      rd(`CPUSC_ADDR_FLAGS, 8'h01);
      ex(cpusc_pkg::CPUSC_OP_MUL, 16'h8000, 1'b1, 4'hA);
      rd(`CPUSC_ADDR_FLAGS, 8'h06);
      ex(cpusc_pkg::CPUSC_OP_MOVE, 16'hFF00, 1'b0, 4'hF);
      rd(`CPUSC_ADDR_FLAGS, 8'h05);
      ex(cpusc_pkg::CPUSC_OP_KEEP, 16'h0080, 1'b0, 4'hF);
      rd(`CPUSC_ADDR_FLAGS, 8'h05);
      ex(cpusc_pkg::CPUSC_OP_SHIFT, 16'h0001, 1'b0, 4'h1);
      #1;
      `CHK(sfr_rdata[7], 1'b1)
      ex(cpusc_pkg::CPUSC_OP_DIV, 16'h0001, 1'b1, 4'hA);
      #1;
      `CHK({sfr_rdata[7], sfr_rdata[2]}, 2'b01)
      ex(cpusc_pkg::CPUSC_OP_CMPJ, 16'h00FF, 1'b0, 4'h8);
      rd(`CPUSC_ADDR_FLAGS, 8'h86);
      ex(cpusc_pkg::CPUSC_OP_NEG, 16'h0000, 1'b1, 4'h0);
      rd(`CPUSC_ADDR_FLAGS, 8'h81);
      ex(cpusc_pkg::CPUSC_OP_DECADJ, 16'h0010, 1'b0, 4'h6);
      rd(`CPUSC_ADDR_FLAGS, 8'h00);
      // Explicit write collides with an instruction update
      @(posedge clk_sys);
      sfr_addr  <= `CPUSC_ADDR_FLAGS;
      sfr_wr    <= 1'b1;
      sfr_wdata <= 8'h81;
      res_valid <= 1'b1;
      res_op    <= cpusc_pkg::CPUSC_OP_ADD;
      @(posedge clk_sys);
      sfr_wr    <= 1'b0;
      res_valid <= 1'b0;
      rd(`CPUSC_ADDR_FLAGS, 8'h81);
      rd(`CPUSC_ADDR_MODE, 8'hCF);
      // Mode byte write must also suppress the flag update
      @(posedge clk_sys);
      sfr_addr  <= `CPUSC_ADDR_MODE;
      sfr_wr    <= 1'b1;
      sfr_wdata <= 8'hCF;
      res_valid <= 1'b1;
      res_value <= 16'h0000;
      @(posedge clk_sys);
      sfr_wr    <= 1'b0;
      res_valid <= 1'b0;
      rd(`CPUSC_ADDR_FLAGS, 8'h81);
      wr(`CPUSC_ADDR_CONFIG, 8'h0C);
      rd(`CPUSC_ADDR_CONFIG, 8'h0C);
      `CHK({addr_16bit, push_word_only, compat_map}, 3'h7)
      for (int a = 30; a < 34; a++) begin
         @(posedge clk_sys);
         dmem_addr  <= 16'(a);
         ind_via_r1 <= a[0];
         #1;
         `CHK(dmem_is_reg, a < 32)
         `CHK(ind_pointer, a[0] ? 16'h00A5 : 16'h005A)
         `CHK(dmem_bank, 2'(a / 8))
         `CHK(dmem_byte, 3'(a % 8))
      end
      for (int d = 0; d < 4; d++) begin
         wr(`CPUSC_ADDR_CONFIG, 8'(d));
         n = 8'h00;
         repeat (64) @(posedge clk_sys);
         repeat (128) begin
            @(posedge clk_sys);
            #1;
            n += 8'(periph_tick);
         end
         `CHK(n, d == 3 ? 8'h00 : 8'(128 >> (2 * d + 2)))
      end
      @(posedge clk_sys);
      dmem_addr <= 16'h0000;
      #1;
      `CHK(dmem_is_reg, 1'b0)
      `CHK(ind_pointer, 16'hA55A)
      // Mid-run reset returns to large-memory user mode
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(`CPUSC_ADDR_CONFIG, 8'h00);
      `CHK({priv_mode, addr_16bit}, 2'b00)
      finish_test();
   end
endmodule // tb
